// file: src/tqf_queue.v
`timescale 1ns/1ns
`include "tqf_regs.vh"

// Function
// RULE_01: Status bits 12:8 show next index
// RULE_02: Index counts from zero up to depth-1
// RULE_03: Bit 7 set when message aborted
// RULE_04: Bit 6 set on lost arbitration
// RULE_05: Bit 5 set on bus error
// RULE_06: Bit 4 flags attempts exhausted
// RULE_07: Send-request or written zero clears bits
// RULE_08: Outcome bits change only at completion/reset
// RULE_09: Bit 2 high while queue empty
// RULE_10: Bit 0 high while queue has room
// RULE_11: Head address register gives write location
// RULE_12: Host avoids head address in configuration
// RULE_13: Payload code selects 8 to 64 bytes
// RULE_14: Depth is code plus one messages
// RULE_15: Attempts code: none, three, unlimited
// RULE_16: Priority field ranks queue, high wins
// RULE_17: Size, depth, direction, timestamp config-only
// RULE_18: Reset bit held in configuration, auto-clears
// RULE_19: Reset bit resets queue, self-clears
// RULE_20: Send request self-clears; host clear aborts
// RULE_21: Increment advances head or tail
// RULE_22: Direction bit selects transmit or receive
// RULE_23: Empty/not-full from occupancy versus depth
module tqf_queue (
	input wire CLK,
	input wire ARST_N,
	input wire CONFIG_MODE,
	input wire RETRY_LIMIT_EN,
	input wire [1:0] REG_SEL,
	input wire REG_WE,
	input wire REG_RE,
	input wire [31:0] REG_WDATA,
	output reg [31:0] REG_RDATA,
	input wire DONE_OK,
	input wire DONE_FAIL,
	input wire FAIL_ARB_LOST,
	input wire FAIL_BUS_ERR,
	output reg TX_START,
	output reg [4:0] TX_SLOT,
	output reg TX_ABORT,
	output reg [4:0] TX_PRIORITY
);
	// ==========================================
	// Configuration and control state
	reg [2:0] payload_reg;
	reg [4:0] depth_reg;
	reg [1:0] attempts_reg;
	reg dir_reg;
	reg rtr_reg;
	reg tsen_reg;
	reg [4:0] irqen_reg;
	reg fifo_reset_request_reg;
	reg sendreq_reg;
	reg [4:0] head_reg;
	reg [4:0] tail_reg;
	reg [5:0] count_reg;
	reg busy_reg;
	reg [1:0] retry_reg;
	reg pend_arb_reg;
	reg pend_err_reg;
	reg aborted_reg;
	reg arblost_reg;
	reg buserr_reg;
	reg exhaust_reg;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [4:0] fifo_out_data;
	wire wr_ctl;
	wire wr_sta;
	wire incr;
	wire push;
	wire rx_pop;
	wire start;
	wire ok;
	wire fail;
	wire limit_hit;
	wire exhaust;
	wire host_abort;
	wire finish;
	wire finish_abt;
	wire set_req;
	wire clr_req;
	wire flag_clr;
	wire empty;
	wire full;
	wire [5:0] depth_msgs;
	wire [31:0] head_addr;
	// ==========================================
	// Helpers
	function [4:0] next_ptr;
		input [4:0] ptr;
		input [4:0] last;
		begin
			if (ptr == last)
				next_ptr = 5'h00;
			else
				next_ptr = ptr + 5'h01;
		end
	endfunction

	function [6:0] payload_bytes;
		input [2:0] code;
		begin
			case (code)
				3'h0: payload_bytes = 7'h08;
				3'h1: payload_bytes = 7'h0C;
				3'h2: payload_bytes = 7'h10;
				3'h3: payload_bytes = 7'h14;
				3'h4: payload_bytes = 7'h18;
				3'h5: payload_bytes = 7'h20;
				3'h6: payload_bytes = 7'h30;
				default: payload_bytes = 7'h40;
			endcase
		end
	endfunction

	// ==========================================
	// Decode and events
	assign wr_ctl = REG_WE && (REG_SEL == `TQF_IDX_CONTROL);
	assign wr_sta = REG_WE && (REG_SEL == `TQF_IDX_STATUS);
	assign depth_msgs = {1'b0, depth_reg} + 6'h01; // RULE_14
	assign empty = (count_reg == 6'h00); // RULE_23
	assign full = (count_reg == depth_msgs); // RULE_23
	// Increment ignored while the queue is held in reset
	assign incr = wr_ctl && REG_WDATA[`TQF_CTL_INCR] && !fifo_reset_request_reg && !CONFIG_MODE;
	assign push = incr && dir_reg && !full && fifo_in_ready; // RULE_21
	assign rx_pop = incr && !dir_reg && !empty; // RULE_21
	// Only one message in flight; the FIFO backs up behind it
	assign start = !busy_reg && sendreq_reg && fifo_out_valid && !fifo_reset_request_reg;
	assign ok = busy_reg && DONE_OK;
	assign fail = busy_reg && DONE_FAIL && !DONE_OK;
	assign limit_hit = RETRY_LIMIT_EN && ((attempts_reg == `TQF_ATTEMPTS_NONE) ||
		(attempts_reg == `TQF_ATTEMPTS_THREE && retry_reg == `TQF_RETRY_MAX)); // RULE_15
	assign exhaust = fail && limit_hit; // RULE_06
	assign clr_req = wr_ctl && sendreq_reg && !REG_WDATA[`TQF_CTL_SENDREQ];
	assign host_abort = busy_reg && clr_req && !ok; // RULE_20
	assign finish_abt = !ok && (exhaust || host_abort);
	assign finish = ok || finish_abt;
	assign set_req = wr_ctl && dir_reg && !sendreq_reg && REG_WDATA[`TQF_CTL_SENDREQ] && !fifo_reset_request_reg;
	assign flag_clr = set_req; // RULE_07
	assign head_addr = `TQF_RAM_BASE + {20'h00000, {7'h00, head_reg} *
		{5'h00, payload_bytes(payload_reg) + `TQF_HEADER_BYTES}}; // RULE_11 RULE_13

	tqf_fifo #(
		.WIDTH(5),
		.DEPTH(`TQF_FIFO_DEPTH),
		.AW(`TQF_FIFO_AW)
	) u_fifo (
		.CLK(CLK),
		.ARST_N(ARST_N),
		.flush(fifo_reset_request_reg),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data(head_reg),
		.out_valid(fifo_out_valid),
		.out_ready(start),
		.out_data(fifo_out_data)
	);

	// ==========================================
	// Configuration fields
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			payload_reg <= 3'h0;
			depth_reg <= 5'h00;
			attempts_reg <= `TQF_ATTEMPTS_RST;
			TX_PRIORITY <= 5'h00;
			dir_reg <= 1'b0;
			rtr_reg <= 1'b0;
			tsen_reg <= 1'b0;
			irqen_reg <= 5'h00;
		end else if (wr_ctl) begin
			if (CONFIG_MODE) begin
				payload_reg <= REG_WDATA[`TQF_CTL_PAYLOAD_HI:`TQF_CTL_PAYLOAD_LO]; // RULE_17
				depth_reg <= REG_WDATA[`TQF_CTL_DEPTH_HI:`TQF_CTL_DEPTH_LO]; // RULE_17
				dir_reg <= REG_WDATA[`TQF_CTL_DIR]; // RULE_17 RULE_22
				tsen_reg <= REG_WDATA[`TQF_CTL_TSEN]; // RULE_17
			end
			attempts_reg <= REG_WDATA[`TQF_CTL_ATTEMPTS_HI:`TQF_CTL_ATTEMPTS_LO];
			TX_PRIORITY <= REG_WDATA[`TQF_CTL_PRIO_HI:`TQF_CTL_PRIO_LO]; // RULE_16
			rtr_reg <= REG_WDATA[`TQF_CTL_RTR];
			irqen_reg <= REG_WDATA[`TQF_CTL_IRQEN_HI:`TQF_CTL_IRQEN_LO];
		end
	end

	// ==========================================
	// Queue reset and send request
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			fifo_reset_request_reg <= 1'b1;
			sendreq_reg <= 1'b0;
		end else begin
			if (CONFIG_MODE)
				fifo_reset_request_reg <= 1'b1; // RULE_18
			else if (wr_ctl && REG_WDATA[`TQF_CTL_FIFO_RESET_REQUEST])
				fifo_reset_request_reg <= 1'b1; // RULE_19
			else
				fifo_reset_request_reg <= 1'b0; // RULE_18 RULE_19
			if (fifo_reset_request_reg)
				sendreq_reg <= 1'b0;
			else if (set_req)
				sendreq_reg <= 1'b1; // RULE_20
			else if (clr_req)
				sendreq_reg <= 1'b0; // RULE_20
			else if (ok && count_reg == 6'h01 && !push)
				sendreq_reg <= 1'b0; // RULE_20
		end
	end

	// ==========================================
	// Pointers and occupancy
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			head_reg <= 5'h00;
			tail_reg <= 5'h00;
			count_reg <= 6'h00;
		end else if (fifo_reset_request_reg) begin
			head_reg <= 5'h00; // RULE_19
			tail_reg <= 5'h00;
			count_reg <= 6'h00;
		end else begin
			if (push)
				head_reg <= next_ptr(head_reg, depth_reg); // RULE_21
			if (finish || rx_pop)
				tail_reg <= next_ptr(tail_reg, depth_reg); // RULE_02 RULE_21
			if (push && !finish)
				count_reg <= count_reg + 6'h01;
			else if ((finish || rx_pop) && !push)
				count_reg <= count_reg - 6'h01;
		end
	end

	// ==========================================
	// In-flight message and retries
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			busy_reg <= 1'b0;
			retry_reg <= 2'h0;
			pend_arb_reg <= 1'b0;
			pend_err_reg <= 1'b0;
			TX_START <= 1'b0;
			TX_SLOT <= 5'h00;
			TX_ABORT <= 1'b0;
		end else begin
			TX_START <= start;
			TX_ABORT <= host_abort || (busy_reg && fifo_reset_request_reg);
			if (start)
				TX_SLOT <= fifo_out_data;
			if (fifo_reset_request_reg || finish) begin
				busy_reg <= 1'b0;
			end else if (start) begin
				busy_reg <= 1'b1;
				retry_reg <= 2'h0;
				pend_arb_reg <= 1'b0;
				pend_err_reg <= 1'b0;
			end else if (fail) begin
				// Saturates; only the three-retry code reads it
				if (retry_reg != `TQF_RETRY_MAX)
					retry_reg <= retry_reg + 2'h1; // RULE_15
				pend_arb_reg <= pend_arb_reg | FAIL_ARB_LOST;
				pend_err_reg <= pend_err_reg | FAIL_BUS_ERR;
			end
		end
	end

	// ==========================================
	// Outcome flags, set wins over clear
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			aborted_reg <= 1'b0;
			arblost_reg <= 1'b0;
			buserr_reg <= 1'b0;
			exhaust_reg <= 1'b0;
		end else if (fifo_reset_request_reg) begin
			aborted_reg <= 1'b0; // RULE_08
			arblost_reg <= 1'b0;
			buserr_reg <= 1'b0;
			exhaust_reg <= 1'b0;
		end else begin
			if (finish) begin
				aborted_reg <= finish_abt; // RULE_03 RULE_08
				arblost_reg <= pend_arb_reg | (fail & FAIL_ARB_LOST); // RULE_04 RULE_08
				buserr_reg <= pend_err_reg | (fail & FAIL_BUS_ERR); // RULE_05 RULE_08
			end else begin
				if (flag_clr || (wr_sta && !REG_WDATA[`TQF_STA_ABORTED]))
					aborted_reg <= 1'b0; // RULE_07
				if (flag_clr || (wr_sta && !REG_WDATA[`TQF_STA_ARBLOST]))
					arblost_reg <= 1'b0; // RULE_07
				if (flag_clr || (wr_sta && !REG_WDATA[`TQF_STA_BUSERR]))
					buserr_reg <= 1'b0; // RULE_07
			end
			if (exhaust)
				exhaust_reg <= 1'b1; // RULE_06
			else if (wr_sta && !REG_WDATA[`TQF_STA_EXHAUST])
				exhaust_reg <= 1'b0;
		end
	end

	// ==========================================
	// Read data, one cycle after the strobe
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			REG_RDATA <= 32'h00000000;
		end else if (REG_RE) begin
			REG_RDATA <= 32'h00000000;
			case (REG_SEL)
				`TQF_IDX_STATUS: begin
					REG_RDATA[`TQF_STA_INDEX_HI:`TQF_STA_INDEX_LO] <= tail_reg; // RULE_01 RULE_02
					REG_RDATA[`TQF_STA_ABORTED] <= aborted_reg; // RULE_03
					REG_RDATA[`TQF_STA_ARBLOST] <= arblost_reg; // RULE_04
					REG_RDATA[`TQF_STA_BUSERR] <= buserr_reg; // RULE_05
					REG_RDATA[`TQF_STA_EXHAUST] <= exhaust_reg && dir_reg; // RULE_06
					REG_RDATA[`TQF_STA_EMPTY] <= empty; // RULE_09
					REG_RDATA[`TQF_STA_NOTFULL] <= !full; // RULE_10
				end
				// Head address is meaningless during configuration
				`TQF_IDX_HEAD_ADDR: REG_RDATA <= head_addr; // RULE_11
				`TQF_IDX_CONTROL: begin
					REG_RDATA[`TQF_CTL_PAYLOAD_HI:`TQF_CTL_PAYLOAD_LO] <= payload_reg;
					REG_RDATA[`TQF_CTL_DEPTH_HI:`TQF_CTL_DEPTH_LO] <= depth_reg;
					REG_RDATA[`TQF_CTL_ATTEMPTS_HI:`TQF_CTL_ATTEMPTS_LO] <= attempts_reg;
					REG_RDATA[`TQF_CTL_PRIO_HI:`TQF_CTL_PRIO_LO] <= TX_PRIORITY;
					REG_RDATA[`TQF_CTL_FIFO_RESET_REQUEST] <= fifo_reset_request_reg;
					REG_RDATA[`TQF_CTL_SENDREQ] <= sendreq_reg;
					REG_RDATA[`TQF_CTL_DIR] <= dir_reg;
					REG_RDATA[`TQF_CTL_RTR] <= rtr_reg;
					REG_RDATA[`TQF_CTL_TSEN] <= tsen_reg;
					REG_RDATA[`TQF_CTL_IRQEN_HI:`TQF_CTL_IRQEN_LO] <= irqen_reg;
				end
				default: REG_RDATA <= 32'h00000000;
			endcase
		end
	end
endmodule

// file: src/tqf_regs.vh
`ifndef TQF_REGS_VH
`define TQF_REGS_VH

// ==========================================
// Register word indices
`define TQF_IDX_STATUS 2'h0
`define TQF_IDX_HEAD_ADDR 2'h1
`define TQF_IDX_CONTROL 2'h2

// ==========================================
// Control register fields
`define TQF_CTL_PAYLOAD_HI 31
`define TQF_CTL_PAYLOAD_LO 29
`define TQF_CTL_DEPTH_HI 28
`define TQF_CTL_DEPTH_LO 24
`define TQF_CTL_ATTEMPTS_HI 22
`define TQF_CTL_ATTEMPTS_LO 21
`define TQF_CTL_PRIO_HI 20
`define TQF_CTL_PRIO_LO 16
`define TQF_CTL_FIFO_RESET_REQUEST 10
`define TQF_CTL_SENDREQ 9
`define TQF_CTL_INCR 8
`define TQF_CTL_DIR 7
`define TQF_CTL_RTR 6
`define TQF_CTL_TSEN 5
`define TQF_CTL_IRQEN_HI 4
`define TQF_CTL_IRQEN_LO 0

// ==========================================
// Status register fields
`define TQF_STA_INDEX_HI 12
`define TQF_STA_INDEX_LO 8
`define TQF_STA_ABORTED 7
`define TQF_STA_ARBLOST 6
`define TQF_STA_BUSERR 5
`define TQF_STA_EXHAUST 4
`define TQF_STA_EMPTY 2
`define TQF_STA_NOTFULL 0

// ==========================================
// Reset values and codes
`define TQF_ATTEMPTS_RST 2'h3
`define TQF_ATTEMPTS_NONE 2'h0
`define TQF_ATTEMPTS_THREE 2'h1
`define TQF_RETRY_MAX 2'h3
`define TQF_RAM_BASE 32'h00000400
`define TQF_HEADER_BYTES 7'h08
`define TQF_FIFO_DEPTH 32
`define TQF_FIFO_AW 5

`endif

// file: src/tqf_fifo.v
`timescale 1ns/1ns
`include "tqf_regs.vh"

module tqf_fifo #(
	parameter WIDTH = 5,
	parameter DEPTH = `TQF_FIFO_DEPTH,
	parameter AW = `TQF_FIFO_AW
) (
	input wire CLK,
	input wire ARST_N,
	input wire flush,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_reg;
	reg [AW-1:0] rd_ptr_reg;
	reg [AW:0] count_reg;
	wire push;
	wire pop;
	integer i;

	assign in_ready = (count_reg != DEPTH[AW:0]);
	assign out_valid = (count_reg != {(AW+1){1'b0}});
	assign out_data = mem_reg[rd_ptr_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// ==========================================
	// Pointers and occupancy
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
		end else if (flush) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			if (push && !pop)
				count_reg <= count_reg + 1'b1;
			else if (pop && !push)
				count_reg <= count_reg - 1'b1;
		end
	end

	// ==========================================
	// Storage, no reset needed on data
	always @(posedge CLK) begin
		for (i = 0; i < DEPTH; i = i + 1) begin
			if (push && wr_ptr_reg == i[AW-1:0])
				mem_reg[i] <= in_data;
		end
	end
endmodule

// file: testbench/tqf_queue_checker.sv
`timescale 1ns/1ns
module tqf_queue_checker (
	input wire CLK,
	input wire ARST_N,
	input wire CONFIG_MODE,
	input wire [1:0] REG_SEL,
	input wire REG_WE,
	input wire REG_RE,
	input wire [31:0] REG_WDATA,
	input wire [31:0] REG_RDATA,
	input wire TX_START,
	input wire TX_ABORT,
	input wire [4:0] TX_PRIORITY
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!ARST_N);
	// ==========================================
	// Last priority written, to judge the output copy
	reg [4:0] prio_w_reg;
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N)
			prio_w_reg <= 5'h00;
		else if (REG_WE && REG_SEL == 2'h2)
			prio_w_reg <= REG_WDATA[20:16];
	end
	sequence ctl_wr;
		REG_WE && REG_SEL == 2'h2;
	endsequence
	sequence sta_rd;
		REG_RE && REG_SEL == 2'h0;
	endsequence
	// ==========================================
	// Properties
	read_hold_a: assert property (!REG_RE |=> $stable(REG_RDATA))
		else $error("read data moved without a read");
	start_pulse_a: assert property (TX_START |=> !TX_START)
		else $error("start longer than one cycle");
	abort_pulse_a: assert property (TX_ABORT |=> !TX_ABORT)
		else $error("abort longer than one cycle");
	status_layout_a: assert property (sta_rd |=> REG_RDATA[31:13] == 19'h00000 &&
		!REG_RDATA[3] && !REG_RDATA[1])
		else $error("unused status bits not zero");
	empty_room_a: assert property (sta_rd |=> !REG_RDATA[2] || REG_RDATA[0])
		else $error("empty queue reported full");
	head_align_a: assert property (REG_RE && REG_SEL == 2'h1 && !CONFIG_MODE |=>
		REG_RDATA[1:0] == 2'h0 && REG_RDATA >= 32'h00000400)
		else $error("head address outside message area");
	prio_follow_a: assert property (ctl_wr ##1 !(REG_WE && REG_SEL == 2'h2) |=> TX_PRIORITY == prio_w_reg)
		else $error("priority output does not follow control write");
	reset_held_a: assert property (REG_RE && REG_SEL == 2'h2 && CONFIG_MODE && $past(CONFIG_MODE) |=>
		REG_RDATA[10])
		else $error("reset bit clear in configuration");
	incr_zero_a: assert property (REG_RE && REG_SEL == 2'h2 |=> !REG_RDATA[8])
		else $error("increment bit reads one");
endmodule
bind tqf_queue tqf_queue_checker chk (.CLK(CLK), .ARST_N(ARST_N), .CONFIG_MODE(CONFIG_MODE), .REG_SEL(REG_SEL),
	.REG_WE(REG_WE), .REG_RE(REG_RE), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .TX_START(TX_START),
	.TX_ABORT(TX_ABORT), .TX_PRIORITY(TX_PRIORITY));

// file: testbench/tqf_engine_model.sv
`timescale 1ns/1ns
module tqf_engine_model (
	input wire CLK,
	input wire ARST_N,
	input wire TX_START,
	input wire TX_ABORT,
	input wire [1:0] mode,
	input wire [3:0] delay,
	output reg done_ok,
	output reg done_fail,
	output reg arb_lost,
	output reg bus_err
);
	// ==========================================
	// Mode 0 succeeds, 1 loses arbitration, 2 bus error, 3 stalls
	reg busy_reg;
	reg tog_reg;
	reg [3:0] cnt_reg;
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			busy_reg <= 1'b0;
			tog_reg <= 1'b0;
			cnt_reg <= 4'h0;
			done_ok <= 1'b0;
			done_fail <= 1'b0;
			arb_lost <= 1'b0;
			bus_err <= 1'b0;
		end else begin
			tog_reg <= ~tog_reg;
			done_ok <= 1'b0;
			done_fail <= 1'b0;
			// Cause lines toggle when unqualified, so a design must not trust them
			arb_lost <= tog_reg;
			bus_err <= ~tog_reg;
			if (TX_START) begin
				busy_reg <= 1'b1;
				cnt_reg <= delay;
			end else if (TX_ABORT)
				busy_reg <= 1'b0;
			else if (busy_reg && cnt_reg != 4'h0)
				cnt_reg <= cnt_reg - 4'h1;
			else if (busy_reg && mode == 2'h0) begin
				done_ok <= 1'b1;
				busy_reg <= 1'b0;
			end else if (busy_reg && mode != 2'h3) begin
				done_fail <= 1'b1;
				arb_lost <= (mode == 2'h1);
				bus_err <= (mode == 2'h2);
				cnt_reg <= delay;
			end
		end
	end
endmodule

// file: testbench/test_can_tx_queue_and_fifo_config.sv
`timescale 1ns/1ns
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin miscompares++; \
	$display("unexpected at %0t: got %h want %h", $time, got, exp); end end
module test_can_tx_queue_and_fifo_config;
	reg CLK = 1'b0, ARST_N = 1'b0, CONFIG_MODE = 1'b1, RETRY_LIMIT_EN = 1'b1, REG_WE = 1'b0, REG_RE = 1'b0;
	reg [1:0] REG_SEL = 2'h0;
	reg [31:0] REG_WDATA = 32'h00000000;
	wire [31:0] REG_RDATA;
	wire DONE_OK, DONE_FAIL, FAIL_ARB_LOST, FAIL_BUS_ERR, TX_START, TX_ABORT;
	wire [4:0] TX_SLOT, TX_PRIORITY;
	reg [1:0] eng_mode = 2'h0;
	reg [3:0] eng_delay = 4'h2;
	reg [31:0] rv;
	reg [2:0] pl;
	reg [4:0] pri, irq;
	int miscompares = 0, num_checks = 0, starts = 0, aborts = 0, k, n;
	int bytes_tbl[8] = '{8, 12, 16, 20, 24, 32, 48, 64};
	tqf_queue dut (.CLK(CLK), .ARST_N(ARST_N), .CONFIG_MODE(CONFIG_MODE), .RETRY_LIMIT_EN(RETRY_LIMIT_EN),
		.REG_SEL(REG_SEL), .REG_WE(REG_WE), .REG_RE(REG_RE), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
		.DONE_OK(DONE_OK), .DONE_FAIL(DONE_FAIL), .FAIL_ARB_LOST(FAIL_ARB_LOST), .FAIL_BUS_ERR(FAIL_BUS_ERR),
		.TX_START(TX_START), .TX_SLOT(TX_SLOT), .TX_ABORT(TX_ABORT), .TX_PRIORITY(TX_PRIORITY));
	tqf_engine_model eng (.CLK(CLK), .ARST_N(ARST_N), .TX_START(TX_START), .TX_ABORT(TX_ABORT), .mode(eng_mode),
		.delay(eng_delay), .done_ok(DONE_OK), .done_fail(DONE_FAIL), .arb_lost(FAIL_ARB_LOST), .bus_err(FAIL_BUS_ERR));
	initial begin
		forever #25 CLK = ~CLK;
	end
	// ==========================================
	// Slots must be handed out in queue order, depth four
	always @(posedge CLK) begin
		if (TX_START) begin
			`CHK(TX_SLOT, {3'h0, starts[1:0]})
			starts++;
		end
		if (TX_ABORT)
			aborts++;
	end
	// ==========================================
	// Expectations
	function [31:0] ctl(input [1:0] at, input sr, input inc, input fr);
		ctl = {pl, 5'h03, 1'b0, at, pri, 5'h00, fr, sr, inc, 1'b1, 2'b00, irq};
	endfunction
	function [31:0] sta(input [4:0] idx, input ab, input arb, input err, input ex, input emp, input nf);
		sta = {19'h00000, idx, ab, arb, err, ex, 1'b0, emp, 1'b0, nf};
	endfunction
	function [31:0] head(input int h);
		head = 32'h00000400 + h * (bytes_tbl[pl] + 8);
	endfunction
	// ==========================================
	// Register port
	task wr(input [1:0] s, input [31:0] d);
		@(negedge CLK);
		REG_SEL = s;
		REG_WDATA = d;
		REG_WE = 1'b1;
		@(negedge CLK);
		REG_WE = 1'b0;
	endtask
	task rd(input [1:0] s, output [31:0] d);
		@(negedge CLK);
		REG_SEL = s;
		REG_RE = 1'b1;
		@(negedge CLK);
		REG_RE = 1'b0;
		d = REG_RDATA;
	endtask
	// Bounded wait; after 300 re-reads the host moves on even if the bit never settles
	task poll(input [1:0] s, input int b, input v);
		int i;
		i = 0;
		rd(s, rv);
		while (rv[b] !== v && i < 300) begin
			rd(s, rv);
			i++;
		end
		if (rv[b] !== v) begin
			miscompares++;
			$display("unexpected at %0t: bit %0d never settled", $time, b);
		end
	endtask
	task report_and_stop;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		#(50 * 20000);
		miscompares++;
		$display("unexpected at %0t: watchdog expired", $time);
		report_and_stop;
	end
	// ==========================================
	// Main sequence
	initial begin
		rv = $urandom(656);
		pl = $urandom;
		pri = $urandom;
		irq = $urandom;
		eng_delay = $urandom % 6;
		repeat (12) @(negedge CLK);
		ARST_N = 1'b1;
		rd(0, rv);
		`CHK(rv, sta(0, 0, 0, 0, 0, 1, 1))
		rd(2, rv);
		`CHK(rv, 32'h00600400)
		wr(2, ctl(2'h1, 0, 0, 0));
		rd(2, rv);
		`CHK(rv, ctl(2'h1, 0, 0, 1))
		CONFIG_MODE = 1'b0;
		poll(2, 10, 1'b0);
		// Config-only fields flipped outside configuration must not move
		wr(2, ctl(2'h1, 0, 0, 0) ^ 32'hFF0000A0);
		rd(2, rv);
		`CHK(rv, ctl(2'h1, 0, 0, 0))
		for (k = 0; k < 6; k++) begin
			n = (k > 4) ? 4 : k;
			rd(0, rv);
			`CHK(rv, sta(0, 0, 0, 0, 0, n == 0, n < 4))
			rd(1, rv);
			`CHK(rv, head(n % 4))
			wr(2, ctl(2'h1, 0, 1, 0));
		end
		wr(2, ctl(2'h1, 1, 0, 0));
		poll(2, 9, 1'b0);
		rd(0, rv);
		`CHK(rv, sta(0, 0, 0, 0, 0, 1, 1))
		`CHK(starts, 4)
		// Arbitration loss with three retries, then bus error with none
		for (k = 0; k < 2; k++) begin
			eng_mode = k + 1;
			wr(2, ctl(k ? 2'h0 : 2'h1, 0, 1, 0));
			wr(2, ctl(k ? 2'h0 : 2'h1, 1, 0, 0));
			poll(0, 2, 1'b1);
			rd(0, rv);
			`CHK(rv, sta(k + 1, 1, k == 0, k == 1, 1, 1, 1))
		end
		eng_mode = 2'h3;
		wr(2, ctl(2'h0, 0, 1, 0));
		wr(2, ctl(2'h0, 1, 0, 0));
		rd(0, rv);
		`CHK(rv, sta(2, 0, 0, 0, 1, 0, 1))
		wr(2, ctl(2'h0, 0, 0, 0));
		poll(0, 2, 1'b1);
		rd(0, rv);
		`CHK(rv, sta(3, 1, 0, 0, 1, 1, 1))
		`CHK(aborts, 1)
		wr(0, 32'h00000000);
		rd(0, rv);
		`CHK(rv, sta(3, 0, 0, 0, 0, 1, 1))
		// Limit off with code 00, then on with an unlimited code: failures never exhaust
		eng_mode = 2'h1;
		for (k = 0; k < 2; k++) begin
			RETRY_LIMIT_EN = (k == 1);
			wr(2, ctl(k ? 2'h2 : 2'h0, 0, 1, 0));
			wr(2, ctl(k ? 2'h2 : 2'h0, 1, 0, 0));
			repeat (40) @(negedge CLK);
			rd(0, rv);
			`CHK(rv, sta((3 + k) % 4, 0, 0, 0, 0, 0, 1))
			wr(2, ctl(k ? 2'h2 : 2'h0, 0, 0, 0));
			poll(0, 2, 1'b1);
			rd(0, rv);
			`CHK(rv, sta(k, 1, 1, 0, 0, 1, 1))
		end
		`CHK(aborts, 3)
		wr(2, ctl(2'h0, 0, 1, 0));
		wr(2, ctl(2'h0, 0, 0, 1));
		poll(2, 10, 1'b0);
		rd(0, rv);
		`CHK(rv, sta(0, 0, 0, 0, 0, 1, 1))
		rd(1, rv);
		`CHK(rv, head(0))
		// Receive direction: send request and head increment are refused
		CONFIG_MODE = 1'b1;
		wr(2, ctl(2'h0, 0, 0, 0) & 32'hFFFFFF7F);
		rd(2, rv);
		`CHK(rv, ctl(2'h0, 0, 0, 1) & 32'hFFFFFF7F)
		CONFIG_MODE = 1'b0;
		poll(2, 10, 1'b0);
		wr(2, ctl(2'h0, 1, 1, 0) & 32'hFFFFFF7F);
		rd(2, rv);
		`CHK(rv, ctl(2'h0, 0, 0, 0) & 32'hFFFFFF7F)
		rd(1, rv);
		`CHK(rv, head(0))
		`CHK(starts, 9)
		rd(3, rv);
		`CHK(rv, 32'h00000000)
		report_and_stop;
	end
endmodule
